// ==== hw/gp5_port.sv ====
// Purpose: eight-pin general port with wake-up select, apb register access
// Assumes: pins synchronous to pclk; lcd select field and segment data inputs
// Notes:   wake-up event handling lives elsewhere; this block only flags pins
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// R1: eight-bit output latch, one bit per pin
// R2: direction 1: read returns latch value
// R3: direction 0: read returns pin level
// R4: direction 1 output, 0 input
// R5: direction/latch set the drive only of general i/o pins
// R6: direction write only, reads all ones
// R7: input pin pull-up follows its enable bit
// R8: mode bit 0 general, 1 wake-up
// R9: reset clears all four registers
// R10: segment select overrides mode and direction
// R11: wake-up pin is never driven whatever its direction bit; direction 1 still drops its pull-up
// R12: sleep modes hold pins, active modes normal
// R13: standby/watch high impedance, pull-up gives high
// R14: output pins never pulled up; off after reset
// R15: latch, pull-up, mode read back, write next edge
module gp5_port
  import gpio5_pkg::*;
(
  input  wire logic        pclk,          // system clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb direction
  input  wire logic [31:0] paddr,         // apb address
  input  wire logic [31:0] pwdata,        // apb write data
  input  wire logic [3:0]  pstrb,         // apb byte strobes
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic [3:0]  lcd_segment_select_field, // from lcd port control
  input  wire logic [7:0]  lcd_segment_output,       // segment levels
  input  wire logic [7:0]  general_port_pin_in,      // sampled pin levels
  output logic      [7:0]  general_port_pin_out,     // pin drive level
  output logic      [7:0]  general_port_pin_oe_n,    // low while driving
  output logic      [7:0]  pullup_on,                // pull-up control
  output logic      [7:0]  wakeup_input              // pin acts as wake-up
);

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  port_output_latch_r;    // output latch [R1]
  logic [7:0]  pin_direction_r;        // direction bits
  logic [7:0]  pullup_enable_r;        // pull-up enable bits
  logic [7:0]  pin_function_select_r;  // wake-up select bits
  gp5_mode_t   pwr_mode_r;             // power mode
  logic [31:0] prdata_r;               // read data
  logic        pready_r;               // answer flag
  logic        pslverr_r;              // error flag
  logic [7:0]  pin_out_r;              // pad drive flops
  logic [7:0]  pin_oe_n_r;
  logic [7:0]  pu_r;
  logic [7:0]  wake_r;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  // pready is answered one cycle into the access phase, so each transfer
  // takes three edges; simpler than a zero-wait answer with registered outputs
  wire        access   = psel & penable & ~pready_r;
  wire        wr_en    = access & pwrite & pstrb[0];
  wire        rd_en    = access & ~pwrite;
  // full 32-bit match: misaligned or aliased addresses are refused
  wire        hit_func = (paddr == GP5_ADDR_FUNC_SEL);
  wire        hit_lat  = (paddr == GP5_ADDR_OUT_LAT);
  wire        hit_pu   = (paddr == GP5_ADDR_PULLUP);
  wire        hit_dir  = (paddr == GP5_ADDR_DIR);
  wire        hit_pwr  = (paddr == GP5_ADDR_PWR);
  wire        hit_any  = hit_func | hit_lat | hit_pu | hit_dir | hit_pwr;

  // port read: latch for outputs, pin level for inputs [R2] [R3]
  wire [7:0] port_view = (pin_direction_r & port_output_latch_r)
                       | (~pin_direction_r & general_port_pin_in);

  // read mux, if/else chain
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_lat)
      rd_byte = port_view;
    else if (hit_dir)
      rd_byte = GP5_DIR_READBACK;                 // write only register [R6]
    else if (hit_pu)
      rd_byte = pullup_enable_r;                  // stored value [R15]
    else if (hit_func)
      rd_byte = pin_function_select_r;            // stored value [R15]
    else if (hit_pwr)
      rd_byte = {5'h00, pwr_mode_r};
  end

  // mode legality: unknown codes keep the previous mode
  wire       pwr_ok = (pwdata[2:0] <= 3'h5);
  wire       hold   = (pwr_mode_r == GP5_MODE_SLEEP) | (pwr_mode_r == GP5_MODE_SUBSLEEP);
  wire       hiz    = (pwr_mode_r == GP5_MODE_STANDBY) | (pwr_mode_r == GP5_MODE_WATCH);

  //////////////////////////////////////////////////////////////////////////////
  // pin function decode
  wire [7:0] seg_pin;
  wire [7:0] wake_pin;   // wake-up use per pin
  gp5_pad_t  pad;
  gp5_seg_decode u_seg
  (
    .seg_sel (lcd_segment_select_field),
    .seg_pin (seg_pin)
  );

  gp5_pin_mux u_mux
  (
    .out_lat  (port_output_latch_r),
    .dir      (pin_direction_r),
    .pu       (pullup_enable_r),
    .func     (pin_function_select_r),
    .seg_pin  (seg_pin),
    .seg_data (lcd_segment_output),
    .hiz_mode (hiz),
    .pad      (pad),
    .gpio_pin (),
    .wake_pin (wake_pin)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register writes; reset clears all [R9] [R14]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_output_latch_r   <= GP5_RST_BYTE;
      pin_direction_r       <= GP5_RST_BYTE;
      pullup_enable_r       <= GP5_RST_BYTE;
      pin_function_select_r <= GP5_RST_BYTE;
      pwr_mode_r            <= GP5_MODE_ACTIVE;
    end
    else if (wr_en)
    begin
      // writes land on the access edge [R15]
      if (hit_lat)  port_output_latch_r   <= pwdata[7:0];
      if (hit_dir)  pin_direction_r       <= pwdata[7:0];
      if (hit_pu)   pullup_enable_r       <= pwdata[7:0];
      if (hit_func) pin_function_select_r <= pwdata[7:0];
      if (hit_pwr && pwr_ok) pwr_mode_r   <= gp5_mode_t'(pwdata[2:0]);
    end
  end

  // apb answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= access;
      pslverr_r <= access & ~hit_any;             // unmapped address
      prdata_r  <= rd_en ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  // pad flops: held in sleep modes, follow mux otherwise [R12]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out_r  <= 8'h00;
      pin_oe_n_r <= 8'hFF;                        // all inputs after reset
      pu_r       <= 8'h00;
      wake_r     <= 8'h00;
    end
    else if (!hold)
    begin
      pin_out_r  <= pad.dout;                     // [R10]
      pin_oe_n_r <= pad.oe_n;                     // [R4] [R5] [R13]
      pu_r       <= pad.pu_en;                    // [R7]
      wake_r     <= wake_pin;                     // [R8] [R11]
    end
  end

  assign prdata                = prdata_r;
  assign pready                = pready_r;
  assign pslverr               = pslverr_r;
  assign general_port_pin_out  = pin_out_r;
  assign general_port_pin_oe_n = pin_oe_n_r;
  assign pullup_on             = pu_r;
  assign wakeup_input          = wake_r;

endmodule // gp5_port

// ==== shared/gpio5_pkg.sv ====
// Purpose: constants and carrier types for the eight-pin wake-up capable port
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   the pull-up offset is not word aligned, so every offset is kept as a
//          register index and the bus byte address is four times the index
package gpio5_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (indices)
  localparam logic [15:0] GP5_IDX_FUNC_SEL  = 16'hFFCC; // pin function select
  localparam logic [15:0] GP5_IDX_OUT_LAT   = 16'hFFD8; // output latch / pin read
  localparam logic [15:0] GP5_IDX_PULLUP    = 16'hFFE2; // pull-up enable
  localparam logic [15:0] GP5_IDX_DIR       = 16'hFFE8; // direction, write only
  localparam logic [15:0] GP5_IDX_PWR       = 16'hFFF0; // power mode select

  // byte addresses on the bus: index times four
  localparam logic [31:0] GP5_ADDR_FUNC_SEL = {14'h0000, GP5_IDX_FUNC_SEL, 2'b00};
  localparam logic [31:0] GP5_ADDR_OUT_LAT  = {14'h0000, GP5_IDX_OUT_LAT, 2'b00};
  localparam logic [31:0] GP5_ADDR_PULLUP   = {14'h0000, GP5_IDX_PULLUP, 2'b00};
  localparam logic [31:0] GP5_ADDR_DIR      = {14'h0000, GP5_IDX_DIR, 2'b00};
  localparam logic [31:0] GP5_ADDR_PWR      = {14'h0000, GP5_IDX_PWR, 2'b00};

  // reset values
  localparam logic [7:0]  GP5_RST_BYTE      = 8'h00;    // all four port registers
  localparam logic [7:0]  GP5_DIR_READBACK  = 8'hFF;    // direction reads as ones
  localparam logic [2:0]  GP5_RST_PWR       = 3'h0;     // active after reset
  localparam int          GP5_NPINS         = 8;        // pins in the port
  localparam int          GP5_SEG_SEL_W     = 4;        // segment select field width

  // operating modes of the chip seen by the port
  typedef enum logic [2:0] {
    GP5_MODE_ACTIVE    = 3'b000,
    GP5_MODE_SUBACTIVE = 3'b001,
    GP5_MODE_SLEEP     = 3'b010,
    GP5_MODE_SUBSLEEP  = 3'b011,
    GP5_MODE_STANDBY   = 3'b100,
    GP5_MODE_WATCH     = 3'b101
  } gp5_mode_t;

  // per-pin drive towards the pad
  typedef struct packed {
    logic [7:0] dout;   // level driven while enabled
    logic [7:0] oe_n;   // low while the port drives the pin
    logic [7:0] pu_en;  // pull-up on
  } gp5_pad_t;

  // apb request carrier
  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } gp5_apb_req_t;

endpackage : gpio5_pkg

// ==== hw/gp5_seg_decode.sv ====
// Purpose: decode of the lcd segment-select field into per-pin segment use
// Assumes: field values follow the pattern 1*** for pins 7..4, 1**1 for 3..0
// Notes:   purely combinational
`timescale 1ns/10ps
module gp5_seg_decode
  import gpio5_pkg::*;
(
  input  wire logic [3:0] seg_sel,   // lcd segment select field
  output wire logic [7:0] seg_pin    // 1: pin is a segment output
);
  // upper nibble is segment whenever the top select bit is set
  wire upper_seg = seg_sel[3];
  // lower nibble also needs the lowest select bit
  wire lower_seg = seg_sel[3] & seg_sel[0];

  assign seg_pin = {{4{upper_seg}}, {4{lower_seg}}};
endmodule // gp5_seg_decode

// ==== hw/gp5_pin_mux.sv ====
// Purpose: per-pin function and power-mode selection for the pad drive
// Assumes: register values already settled
// Notes:   combinational; retention is handled by the top holding its flops
`timescale 1ns/10ps
module gp5_pin_mux
  import gpio5_pkg::*;
(
  input  wire logic [7:0] out_lat,   // output latch
  input  wire logic [7:0] dir,       // direction, 1 = output
  input  wire logic [7:0] pu,        // pull-up enable bits
  input  wire logic [7:0] func,      // wake-up select bits
  input  wire logic [7:0] seg_pin,   // segment use per pin
  input  wire logic [7:0] seg_data,  // segment level per pin
  input  wire logic       hiz_mode,  // standby or watch
  output gp5_pad_t        pad,       // resulting drive
  output wire logic [7:0] gpio_pin,  // pin is general i/o
  output wire logic [7:0] wake_pin   // pin is wake-up input
);
  // general i/o only when neither segment nor wake-up selects it [R5] [R8]
  assign gpio_pin = ~seg_pin & ~func;
  // wake-up overrides direction [R11]
  assign wake_pin = ~seg_pin & func;
  // output enables: segment drives outside standby/watch, general i/o when direction is 1 [R4] [R10]
  wire [7:0] drive = seg_pin | (gpio_pin & dir);
  // pull-up follows its bit only on non-segment pins with direction 0;
  // a wake-up pin whose direction bit is 1 still loses its pull-up [R7] [R14]
  wire [7:0] pu_act = pu & ~seg_pin & ~dir;

  // standby/watch: all drivers off, pull-ups still give a high level [R13]
  assign pad.oe_n  = hiz_mode ? 8'hFF : ~drive;
  assign pad.dout  = (seg_pin & seg_data) | (~seg_pin & out_lat);
  assign pad.pu_en = pu_act;
endmodule // gp5_pin_mux

// ==== sim/gp5_port_sva.sv ====
// Purpose: protocol and pad relation checks on the port
// Assumes: sees only gp5_port ports
// Notes:   bound from tb_top
`timescale 1ns/10ps
module gp5_port_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  general_port_pin_oe_n,
  input wire logic [7:0]  pullup_on,
  input wire logic [7:0]  wakeup_input
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // address names one of the five registers
  wire logic hit = paddr inside {32'h0003_FF30, 32'h0003_FF60, 32'h0003_FF88, 32'h0003_FFA0,
                                 32'h0003_FFC0};
  wire logic done = psel && penable && pready;
  chk_ready_one: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_ready_lat: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_dir_ones: assert property (done && !pwrite && paddr == 32'h0003_FFA0 |-> prdata == 32'h0000_00FF)
    else $error("direction read not all ones");
  chk_upper_zero: assert property (done |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_bad_addr: assert property (done && !hit && !pwrite |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  chk_good_addr: assert property (done && hit |-> !pslverr)
    else $error("mapped access refused");
  chk_no_pull: assert property ((pullup_on & ~general_port_pin_oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  chk_wake_hiz: assert property ((wakeup_input & ~general_port_pin_oe_n) == 8'h00)
    else $error("wake-up pin driven");
endmodule // gp5_port_sva

// ==== sim/gp5_board_model.sv ====
// Purpose: board side of the eight pins
// Assumes: fight lets the board overpower the port on purpose
// Notes:   undriven pins float to the board level unless pulled up
`timescale 1ns/10ps
module gp5_board_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] ext_level,
  input wire logic       fight,
  output logic     [7:0] pin_level
);
  // a pulled-up released pin reads high
  always_comb
    pin_level = fight ? ext_level : ((~oe_n & pin_out) | (oe_n & (pullup_on | ext_level)));
endmodule // gp5_board_model

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the eight-pin port
// Assumes: apb answers one cycle after the first access cycle
// Notes:   random values from an lfsr with a fixed start
`timescale 1ns/10ps
module tb_top import gpio5_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, fight = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, seed = 32'hC6A5, e;
  logic [3:0] pstrb = 4'hF, sel = 0;
  logic [7:0] segd = 0, ext = 0, pin_in, pout, oe_n, pu_on, wk;
  logic [7:0] lat = 0, dir = 0, pu = 0, fn = 0;
  logic [23:0] snap;
  int error_cnt = 0, samples_checked = 0;
  always #4 pclk = ~pclk;
  gp5_port gp5_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lcd_segment_select_field(sel),
    .lcd_segment_output(segd), .general_port_pin_in(pin_in), .general_port_pin_out(pout),
    .general_port_pin_oe_n(oe_n), .pullup_on(pu_on), .wakeup_input(wk));
  gp5_board_model gp5_board_model_inst (.pin_out(pout), .oe_n(oe_n), .pullup_on(pu_on),
    .ext_level(ext), .fight(fight), .pin_level(pin_in));
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected {wake, pull-up, oe_n, drive} from register state
  function automatic logic [31:0] pads(input logic [7:0] l, d, p, f, input logic [3:0] s,
                                       input logic [7:0] sd);
    logic [7:0] sg;
    logic [7:0] drv;
    sg = {{4{s[3]}}, {4{s[3] & s[0]}}};
    drv = sg | (d & ~f);
    return {f & ~sg, p & ~d & ~sg, ~drv, (sg & sd) | (~sg & l & drv)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready, one idle cycle after
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // every pad output against the shadow register state
  task automatic check_pads();
    e = pads(lat, dir, pu, fn, sel, segd);
    chk("oe_n", {24'h0, oe_n}, {24'h0, e[15:8]});
    chk("pin_out", {24'h0, pout & ~e[15:8]}, {24'h0, e[7:0]});
    chk("pullup", {24'h0, pu_on}, {24'h0, e[23:16]});
    chk("wake", {24'h0, wk}, {24'h0, e[31:24]});
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    finish_test();
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_pads();
    apb(1'b0, GP5_ADDR_DIR, 8'h00);
    chk("dir_rd", rd, 32'h0000_00FF);
    apb(1'b0, GP5_ADDR_PULLUP, 8'h00);
    chk("pu_rst", rd, 32'h0);
    apb(1'b0, GP5_ADDR_FUNC_SEL, 8'h00);
    chk("fn_rst", rd, 32'h0);
    // random configurations, first two with segment fields forced
    for (int i = 0; i < 40; i++)
    begin
      seed = lf(lf(seed));
      {fn, pu, dir, lat} = seed;
      sel <= (i == 0) ? 4'h8 : (i == 1) ? 4'h9 : seed[11:8] ^ seed[3:0];
      segd <= seed[19:12];
      ext <= seed[27:20];
      fight <= seed[5];
      apb(1'b1, GP5_ADDR_OUT_LAT, lat);
      apb(1'b1, GP5_ADDR_DIR, dir);
      apb(1'b1, GP5_ADDR_PULLUP, pu);
      apb(1'b1, GP5_ADDR_FUNC_SEL, fn);
      check_pads();
      apb(1'b0, GP5_ADDR_OUT_LAT, 8'h00);
      chk("port_rd", rd, {24'h0, (dir & lat) | (~dir & pin_in)});
      apb(1'b0, GP5_ADDR_PULLUP, 8'h00);
      chk("pu_rd", rd, {24'h0, pu});
      apb(1'b0, GP5_ADDR_FUNC_SEL, 8'h00);
      chk("fn_rd", rd, {24'h0, fn});
    end
    // write without the low strobe leaves the latch alone
    sel <= 4'h0;
    dir = 8'hFF;
    apb(1'b1, GP5_ADDR_DIR, dir);
    pstrb <= 4'h0;
    apb(1'b1, GP5_ADDR_OUT_LAT, ~lat);
    pstrb <= 4'hF;
    apb(1'b0, GP5_ADDR_OUT_LAT, 8'h00);
    chk("strobe", rd, {24'h0, lat});
    apb(1'b0, 32'h0000_FFD0, 8'h00);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    // power modes: hold, high impedance, back to normal
    dir = 8'h0F;
    pu = 8'hFF;
    fn = 8'h00;
    apb(1'b1, GP5_ADDR_DIR, dir);
    apb(1'b1, GP5_ADDR_PULLUP, pu);
    apb(1'b1, GP5_ADDR_FUNC_SEL, fn);
    for (int m = 1; m < 6; m++)
    begin
      snap = {pu_on, oe_n, pout};
      apb(1'b1, GP5_ADDR_PWR, m[7:0]);
      lat = ~lat;
      apb(1'b1, GP5_ADDR_OUT_LAT, lat);
      if (m == 1) check_pads();
      else if (m < 4) chk("hold", {8'h0, pu_on, oe_n, pout}, {8'h0, snap});
      else chk("hiz", {16'h0, pu_on, oe_n}, 32'h0000_F0FF);
      apb(1'b1, GP5_ADDR_PWR, 8'h00);
      check_pads();
    end
    // reserved mode code is ignored, mode stays active
    apb(1'b1, GP5_ADDR_PWR, 8'h07);
    apb(1'b0, GP5_ADDR_PWR, 8'h00);
    chk("pwr_rd", rd, 32'h0);
    finish_test();
  end
endmodule // tb_top
bind gp5_port gp5_port_sva gp5_port_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .general_port_pin_oe_n(general_port_pin_oe_n), .pullup_on(pullup_on),
  .wakeup_input(wakeup_input));
